// ### rtl/pud_pkg.sv
// Constants for the port U input and direction block.
// Assumes a 32-bit AHB-Lite register bus; printed offsets are register indices.
//
// Contract
// RULE_01 - Input register reads anytime; writes to it change nothing.
// RULE_02 - Slew rate control on: input bit reads as one.
// RULE_03 - Slew rate control off: input bit reads the current pin level.
// RULE_04 - Direction register reads and writes anytime, one bit per pin.
// RULE_05 - Direction bit 0 means input, 1 means output, bits 7:0.
// RULE_06 - Enabled stall detector or motor controller forces its pins to output.
// RULE_07 - With both disabled, direction follows the direction register again.
// RULE_08 - Direction register resets to all zeros, every pin an input.
package pud_pkg;
   localparam int          PUD_PINS         = 8;
   localparam logic [11:0] PUD_IDX_INPUT    = 12'h039;
   localparam logic [11:0] PUD_IDX_DIR      = 12'h03A;
   localparam logic [11:0] PUD_IDX_SLEW     = 12'h040;
   localparam logic [7:0]  PUD_DIR_RESET    = 8'h00;
   localparam logic [7:0]  PUD_SLEW_RESET   = 8'h00;
   localparam logic [1:0]  PUD_HTRANS_NSEQ  = 2'h2;
   localparam logic [1:0]  PUD_HTRANS_SEQ   = 2'h3;
endpackage : pud_pkg

// ### rtl/pud_port_u.sv
// Port U: pin input register, direction register and slew control over AHB-Lite.
// Assumes pins are synchronised here; module enables come from the same clock.
`timescale 1ns/1ps
module pud_port_u
   import pud_pkg::*;
#(
   parameter int PINS = PUD_PINS
)
(
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic [7:0]  PORT_U_PINS_IN,
   input  wire logic [7:0]  PORT_U_DRIVE_DATA,
   output logic      [7:0]  PORT_U_PINS_OUT,
   output logic      [7:0]  PORT_U_PINS_OE,
   output logic      [7:0]  PORT_U_SLEW_EN,
   input  wire logic        STALL_DETECTOR_EN,
   input  wire logic [7:0]  STALL_DETECTOR_PINS,
   input  wire logic        MOTOR_CONTROLLER_EN,
   input  wire logic [7:0]  MOTOR_CONTROLLER_PINS
);

   logic [7:0]  pin_meta_r;
   logic [7:0]  pin_sync_r;
   logic [7:0]  direction_bits_r;
   logic [7:0]  slew_r;
   logic        wr_pend_r;
   logic [11:0] wr_idx_r;
   logic [31:0] rdata_nxt;
   logic [7:0]  input_view;
   logic [7:0]  force_out;
   logic [11:0] ap_idx;
   logic        ap_valid;
   logic        ap_read;
   logic        wr_dir;
   logic        wr_slew;
   logic        fwd_dir;
   logic        fwd_slew;
   logic [7:0]  wr_byte;
   logic [7:0]  oe_nxt;

   // One register decode serves the write and forwarding paths; the read path decodes ap_idx in its own case.
   function automatic logic idx_is(input logic [11:0] idx,
                                   input logic [11:0] target);
      return idx == target;
   endfunction

   // Registers are eight bits wide and read back in the low byte of the word.
   function automatic logic [31:0] widen(input logic [7:0] value);
      return {24'h000000, value};
   endfunction

   // The pin ports are eight bits wide, so no other pin count can be served.
   if (PINS != 8) begin : g_pins_check
      $error("pud_port_u: PINS must be 8");
   end

   // Bus timing: a transfer is taken at the edge that ends its address phase.
   // Reads are answered from that address phase, so HRDATA stands one cycle later.
   // Write data arrives one cycle later, in the data phase, and lands at its end.
   // A read whose address phase overlaps the data phase of a write to the same
   // register is handed the new byte, so a pipelined master never reads stale data.
   // The slave never stretches a transfer and always answers OKAY.

   assign ap_idx   = HADDR[13:2];
   assign ap_valid = HSEL && HREADY && (HTRANS == PUD_HTRANS_NSEQ || HTRANS == PUD_HTRANS_SEQ);
   assign ap_read  = ap_valid && !HWRITE;

   // Pins come from outside the clock domain.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pin_meta_r <= 8'h00;
      end else begin
         pin_meta_r <= PORT_U_PINS_IN;
      end
   end

   // Only this second stage is read by any logic.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pin_sync_r <= 8'h00;
      end else begin
         pin_sync_r <= pin_meta_r;
      end
   end

   // A pin under slew control has its input buffer off and reads as one.
   // A pin claimed by an enabled module is an output whatever its direction bit says.
   genvar gi;
   for (gi = 0; gi < PINS; gi++) begin : g_pin
      assign input_view[gi] = slew_r[gi] ? 1'b1 : pin_sync_r[gi];  // [RULE_02] [RULE_03]
      assign oe_nxt[gi]     = force_out[gi] ? 1'b1 : direction_bits_r[gi];  // [RULE_05] [RULE_06] [RULE_07]
   end

   // Write data arrives in the data phase, so the index is held one cycle.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wr_pend_r <= 1'b0;
      end else begin
         wr_pend_r <= ap_valid && HWRITE;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wr_idx_r <= 12'h000;
      end else begin
         wr_idx_r <= ap_idx;
      end
   end

   assign wr_byte  = HWDATA[7:0];
   assign wr_dir   = wr_pend_r && idx_is(wr_idx_r, PUD_IDX_DIR);
   assign wr_slew  = wr_pend_r && idx_is(wr_idx_r, PUD_IDX_SLEW);
   assign fwd_dir  = wr_dir && idx_is(ap_idx, PUD_IDX_DIR);
   assign fwd_slew = wr_slew && idx_is(ap_idx, PUD_IDX_SLEW);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         direction_bits_r <= PUD_DIR_RESET;  // [RULE_08]
      end else if (wr_dir) begin
         direction_bits_r <= wr_byte;  // [RULE_04]
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         slew_r <= PUD_SLEW_RESET;
      end else if (wr_slew) begin
         slew_r <= wr_byte;
      end
   end
   // Writes to the input register index fall through with no effect. [RULE_01]

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (ap_idx)
         PUD_IDX_INPUT: begin
            rdata_nxt = widen(input_view);  // [RULE_01]
         end
         PUD_IDX_DIR: begin
            rdata_nxt = fwd_dir ? widen(wr_byte) : widen(direction_bits_r);  // [RULE_04]
         end
         PUD_IDX_SLEW: begin
            rdata_nxt = fwd_slew ? widen(wr_byte) : widen(slew_r);
         end
         default: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         HRDATA <= 32'h0000_0000;
      end else if (ap_read) begin
         HRDATA <= rdata_nxt;
      end
   end

   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   // Module overrides win over the direction bits while enabled.
   assign force_out = ({8{STALL_DETECTOR_EN}} & STALL_DETECTOR_PINS)
                    | ({8{MOTOR_CONTROLLER_EN}} & MOTOR_CONTROLLER_PINS);  // [RULE_06] [RULE_07]

   // The direction takes effect one cycle after its cause.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PORT_U_PINS_OE <= 8'h00;  // [RULE_08]
      end else begin
         PORT_U_PINS_OE <= oe_nxt;  // [RULE_05] [RULE_06] [RULE_07]
      end
   end

   // Output data is retimed so that it changes together with the enable.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PORT_U_PINS_OUT <= 8'h00;
      end else begin
         PORT_U_PINS_OUT <= PORT_U_DRIVE_DATA;
      end
   end

   // The pad sees the slew control from a flip-flop, never from the bus decode.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PORT_U_SLEW_EN <= 8'h00;
      end else begin
         PORT_U_SLEW_EN <= slew_r;  // [RULE_02]
      end
   end

endmodule // pud_port_u

// ### bench/pud_port_u_assertions.sv
// Checker on the port U top-level ports.
// Bound into the design from the bench top.
`timescale 1ns/1ps
module pud_chk(
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic [31:0] HRDATA,
   input wire logic        STALL_DETECTOR_EN,
   input wire logic        MOTOR_CONTROLLER_EN,
   input wire logic [7:0]  PORT_U_PINS_OE,
   input wire logic [7:0]  PORT_U_PINS_OUT,
   input wire logic [7:0]  PORT_U_DRIVE_DATA,
   input wire logic [7:0]  STALL_DETECTOR_PINS,
   input wire logic [7:0]  MOTOR_CONTROLLER_PINS
);
   wire logic [7:0] frc = ({8{STALL_DETECTOR_EN}}&STALL_DETECTOR_PINS)|({8{MOTOR_CONTROLLER_EN}}&MOTOR_CONTROLLER_PINS);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_ready_okay: assert property (HREADYOUT) else $error("bus answer not ready");
   a_hresp_okay: assert property (!HRESP) else $error("bus answer not okay");
   a_rdata_upper: assert property (HRDATA[31:8]==24'h000000) else $error("read data upper bits set");
   a_force_out: assert property ($past(RSTN) |-> (PORT_U_PINS_OE&$past(frc))==$past(frc))
      else $error("forced pin not output");
   a_out_follow: assert property ($past(RSTN) |-> PORT_U_PINS_OUT==$past(PORT_U_DRIVE_DATA))
      else $error("pin output data not retimed");
   a_oe_reset: assert property ($rose(RSTN) |-> PORT_U_PINS_OE==8'h00) else $error("pin not input after reset");
endmodule // pud_chk

// ### bench/pud_pins.sv
// Pin model: a driven pin shows the output data, an undriven one the outside level.
// Assumes one outside driver per pin.
`timescale 1ns/1ps
module pud_pins(input wire logic [7:0] OE,OUT,EXT, output logic [7:0] PIN);
   assign PIN = (OE&OUT)|(~OE&EXT);
endmodule // pud_pins

// ### bench/pud_port_u_tb_top.sv
// Bench top for port U: AHB-Lite master, random pins and module enables.
// Assumes the design may add wait states; the master waits for ready.
`timescale 1ns/1ps
module pud_port_u_tb_top import pud_pkg::*;;
   logic CLK=0,RSTN=0,HSEL=0,HWRITE=0,SDE=0,MCE=0,HRESP,HREADYOUT;
   logic [1:0] HTRANS=0;
   logic [2:0] HSIZE=2;
   logic [31:0] HADDR=0,HWDATA=0,HRDATA,r;
   logic [7:0] X=0,DRV=0,SDP=0,MCP=0,PIN,OUT,OE,SL,d,s,e;
   int n_errors=0,cmp_count=0;
   pud_port_u dut(.CLK,.RSTN,.HSEL,.HADDR,.HTRANS,.HWRITE,.HSIZE,.HWDATA,.HREADY(HREADYOUT),.HRDATA,.HREADYOUT,
      .HRESP,.PORT_U_PINS_IN(PIN),.PORT_U_DRIVE_DATA(DRV),.PORT_U_PINS_OUT(OUT),.PORT_U_PINS_OE(OE),
      .PORT_U_SLEW_EN(SL),.STALL_DETECTOR_EN(SDE),.STALL_DETECTOR_PINS(SDP),.MOTOR_CONTROLLER_EN(MCE),
      .MOTOR_CONTROLLER_PINS(MCP));
   pud_pins pins(.OE(OE),.OUT(OUT),.EXT(X),.PIN(PIN));
   function logic [7:0] pin_exp(logic [7:0] sl,o,v,x); return sl|(o&v)|(~o&x); endfunction
   task bus(input logic w, input logic [31:0] a,wd, output logic [31:0] rd);
      HSEL<=1; HADDR<=a; HWRITE<=w; HTRANS<=PUD_HTRANS_NSEQ;
      do @(posedge CLK); while (HREADYOUT!==1'b1);
      HTRANS<=2'h0; HWDATA<=wd;
      do @(posedge CLK); while (HREADYOUT!==1'b1);
      rd=HRDATA;
   endtask
   task chk(input logic [31:0] ex,got);
      cmp_count++;
      if (got!==ex) begin n_errors++; $display("mismatch t=%0t exp=%h got=%h",$time,ex,got); end
   endtask
   task finish_test;
      if (n_errors==0 && cmp_count>0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial forever #4 CLK=~CLK;
   initial begin #400000; n_errors++; finish_test; end
   initial begin
      void'($urandom(32'h77656C59));
      repeat (6) @(posedge CLK);
      RSTN<=1;
      @(posedge CLK);
      bus(0,32'hE8,0,r); chk(0,r);
      bus(0,32'h200,0,r); chk(0,r);
      for (int i=0; i<24; i++) begin
         d=(i==0)?8'hFF:$urandom; s=(i<2)?8'h00:$urandom;
         X<=$urandom; DRV<=$urandom; SDE<=(i>3)&$urandom; MCE<=(i>3)&$urandom; SDP<=$urandom; MCP<=$urandom;
         bus(1,32'hE8,d,r); bus(1,32'h100,s,r);
         bus(1,32'hE4,32'hFF,r);
         repeat (4) @(posedge CLK);
         e=d|({8{SDE}}&SDP)|({8{MCE}}&MCP);
         bus(0,32'hE4,0,r); chk({24'h0,pin_exp(s,e,DRV,X)},r);
         bus(0,32'hE8,0,r); chk({24'h0,d},r);
         chk({24'h0,e},{24'h0,OE});
         chk({24'h0,s},{24'h0,SL});
         if (i==12) begin
            RSTN<=0;
            @(posedge CLK);
            RSTN<=1;
            @(posedge CLK);
            bus(0,32'hE8,0,r); chk(0,r);
         end
      end
      finish_test;
   end
endmodule // pud_port_u_tb_top
bind pud_port_u pud_chk chk_i(.CLK,.RSTN,.HREADYOUT,.HRESP,.HRDATA,.STALL_DETECTOR_EN,.MOTOR_CONTROLLER_EN,.PORT_U_PINS_OE,
   .PORT_U_PINS_OUT,.PORT_U_DRIVE_DATA,.STALL_DETECTOR_PINS,.MOTOR_CONTROLLER_PINS);
